// File: design/uei_pkg.sv
package uei_pkg;
    localparam int unsigned DW = 16;
    localparam logic [15:0] OFS_EN0 = 16'h4046;
    localparam logic [15:0] OFS_EN1 = 16'h4048;
    localparam logic [15:0] OFS_ST0 = 16'h404a;
    localparam logic [15:0] OFS_ST1 = 16'h404c;
    localparam logic [15:0] OFS_RAW = 16'h4044;
    localparam int unsigned BIT_HOST = 6;
    localparam int unsigned BIT_RST = 1;
    localparam int unsigned BIT_CFG = 4;
    localparam int unsigned BIT_EPI = 0;
    localparam logic [15:0] MASK0 = 16'h0042;
    localparam logic [15:0] MASK1 = 16'h0051;
    localparam logic [15:0] RST_EN = 16'h0000;
    localparam logic [15:0] RST_ST = 16'h0000;
endpackage : uei_pkg

// File: design/uei_ev_if.sv
`timescale 1ns/100ps
interface uei_ev_if;
    logic [15:0] cond;
    logic [15:0] clr;
    logic [15:0] flags;
    modport bank (input cond, input clr, output flags);
    modport ctl (output cond, output clr, input flags);
endinterface : uei_ev_if

// File: design/uei_flag_bank.sv
`timescale 1ns/100ps
module uei_flag_bank
    import uei_pkg::*;
#(
    parameter logic [15:0] IMPL = 16'hffff
) (
    input wire logic pclk,
    input wire logic presetn,
    uei_ev_if.bank ev
);
    logic [15:0] prev_q;
    logic [15:0] flag_q;
    logic [15:0] rise;
    logic primed_q;

    // no edge in the first cycle after reset: a condition idling high is not an event
    assign rise = ev.cond & ~prev_q & IMPL & {16{primed_q}};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= RST_ST;
            primed_q <= 1'b0;
        end else begin
            prev_q <= ev.cond;
            primed_q <= 1'b1;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= RST_ST;
        end else begin
            flag_q <= ((flag_q & ~ev.clr) | rise) & IMPL;
        end
    end

    assign ev.flags = flag_q;
endmodule : uei_flag_bank

// File: design/uei_top.sv
// Local design decision: register access over APB.
`timescale 1ns/100ps
module uei_top
    import uei_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_connected,
    input wire logic port_reset_event,
    input wire logic device_configured,
    input wire logic endpoint_int,
    output logic irq
);
    typedef enum {S_IDLE, S_ACC} uei_st_e;
    uei_st_e st_q;

    logic [1:0] hc_s;
    logic [1:0] pr_s;
    logic [1:0] dc_s;
    logic [1:0] ep_s;
    logic [15:0] en0_q;
    logic [15:0] en1_q;
    logic [15:0] raw0;
    logic [15:0] raw1;
    logic wr;
    logic rd;
    logic [15:0] wd;

    uei_ev_if ev0 ();
    uei_ev_if ev1 ();

    // offsets are word indices; the byte address is four times the index
    function automatic logic hit(input logic [17:0] a, input logic [15:0] ofs);
        hit = (a == {ofs, 2'b00});
    endfunction : hit

    function automatic logic mapped(input logic [17:0] a);
        mapped = hit(a, OFS_EN0) | hit(a, OFS_EN1) | hit(a, OFS_ST0)
            | hit(a, OFS_ST1) | hit(a, OFS_RAW);
    endfunction : mapped

    // external conditions are asynchronous; two stages before any edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hc_s <= 2'h0;
            pr_s <= 2'h0;
            dc_s <= 2'h0;
            ep_s <= 2'h0;
        end else begin
            hc_s <= {hc_s[0], host_connected};
            pr_s <= {pr_s[0], port_reset_event};
            dc_s <= {dc_s[0], device_configured};
            ep_s <= {ep_s[0], endpoint_int};
        end
    end

    always_comb begin
        raw0 = 16'h0000;
        raw1 = 16'h0000;
        raw0[BIT_HOST] = hc_s[1];
        raw0[BIT_RST] = pr_s[1];
        raw1[BIT_HOST] = ~hc_s[1];
        raw1[BIT_CFG] = dc_s[1];
        raw1[BIT_EPI] = ep_s[1];
    end

    // disconnect flag catches the falling edge of the connection level
    assign ev0.cond = raw0;
    assign ev1.cond = raw1;

    assign wr = (st_q == S_ACC) && psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign wd = pwdata[15:0];

    assign ev0.clr = (wr && hit(paddr, OFS_ST0)) ? wd : 16'h0000;
    assign ev1.clr = (wr && hit(paddr, OFS_ST1)) ? wd : 16'h0000;

    uei_flag_bank #(.IMPL(MASK0)) u_bank0 (
        .pclk(pclk),
        .presetn(presetn),
        .ev(ev0)
    );

    uei_flag_bank #(.IMPL(MASK1)) u_bank1 (
        .pclk(pclk),
        .presetn(presetn),
        .ev(ev1)
    );

    // no wait state: setup, then access answered with pready in its first cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_IDLE;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (psel && !penable) begin
                        st_q <= S_ACC;
                    end
                end
                S_ACC: begin
                    st_q <= S_IDLE;
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= (st_q == S_IDLE) && psel && !penable;
            pslverr <= (st_q == S_IDLE) && psel && !penable && !mapped(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en0_q <= RST_EN;
            en1_q <= RST_EN;
        end else if (wr) begin
            if (hit(paddr, OFS_EN0)) begin
                en0_q <= wd & MASK0;
            end
            if (hit(paddr, OFS_EN1)) begin
                en1_q <= wd & MASK1;
            end
        end
    end

    // read data captured in setup so it is stable through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd) begin
            if (hit(paddr, OFS_EN0)) begin
                prdata <= {16'h0000, en0_q};
            end else if (hit(paddr, OFS_EN1)) begin
                prdata <= {16'h0000, en1_q};
            end else if (hit(paddr, OFS_ST0)) begin
                prdata <= {16'h0000, ev0.flags};
            end else if (hit(paddr, OFS_ST1)) begin
                prdata <= {16'h0000, ev1.flags};
            end else if (hit(paddr, OFS_RAW)) begin
                prdata <= {16'h0000, raw0};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // masked flags still record; only enabled ones reach the request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ev0.flags & en0_q)
                | |(ev1.flags & en1_q);
        end
    end
endmodule : uei_top

// File: tb/uei_top_properties.sv
`timescale 1ns/100ps
module uei_top_properties
    import uei_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic host_connected,
    input wire logic port_reset_event,
    input wire logic device_configured,
    input wire logic endpoint_int,
    input wire logic irq
);
    logic [15:0] en0_q;
    logic [15:0] en1_q;
    wire acc = psel && penable && pready;
    // shadow of the enables, so irq can be judged without peeking inside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en0_q <= 16'h0000;
            en1_q <= 16'h0000;
        end else if (acc && pwrite && paddr == {OFS_EN0, 2'b00}) begin
            en0_q <= pwdata[15:0] & MASK0;
        end else if (acc && pwrite && paddr == {OFS_EN1, 2'b00}) begin
            en1_q <= pwdata[15:0] & MASK1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // sync takes two edges, flag one, irq one more
    sequence s_held(en);
        en ##1 en [*4];
    endsequence
    property p_event(ev, en);
        ev ##0 s_held(en) |-> irq;
    endproperty
    AST_HOST_RISE: assert property (p_event($rose(host_connected), en0_q[6]))
        else $error("no irq after host connect");
    AST_PORT_RESET: assert property (p_event($rose(port_reset_event), en0_q[1]))
        else $error("no irq after port reset");
    AST_ENDPOINT: assert property (p_event($rose(endpoint_int), en1_q[0]))
        else $error("no irq after endpoint event");
    AST_MASKED: assert property ((en0_q == 16'h0000 && en1_q == 16'h0000) [*3] |-> !irq)
        else $error("irq while all masked");
    AST_EN_READ: assert property (acc && !pwrite && paddr == {OFS_EN0, 2'b00} |->
        prdata == {16'h0000, en0_q})
        else $error("enable read mismatch");
    AST_CLEAR: assert property ($stable({host_connected, port_reset_event}) [*3] ##0
        (acc && pwrite && paddr == {OFS_ST0, 2'b00} && pwdata[6] && pwdata[1] && en1_q == 16'h0000)
        ##1 $stable({host_connected, port_reset_event}) [*2] |-> !irq)
        else $error("irq after clear");
endmodule : uei_top_properties
bind uei_top uei_top_properties chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .host_connected, .port_reset_event,
    .device_configured, .endpoint_int, .irq);

// File: tb/test_usb_event_interrupt_mask.sv
`timescale 1ns/100ps
module test_usb_event_interrupt_mask;
    import uei_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [17:0] paddr;
    logic s;
    logic [31:0] pwdata, prdata, d, r, e;
    logic [3:0] ev;
    int n_fail, num_checks, k;
    int bt[5] = '{6, 1, 6, 4, 0};
    logic [3:0] sel[5] = '{4'h8, 4'h4, 4'h8, 4'h2, 4'h1};
    uei_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .host_connected(ev[3]), .port_reset_event(ev[2]),
        .device_configured(ev[1]), .endpoint_int(ev[0]), .irq);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    // idle cycle at the end so no signal is driven twice in one step
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        d = prdata;
        s = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [17:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(d, exp);
    endtask : rd
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ev} = '0;
        presetn = 1'b0;
        n_fail = 0;
        num_checks = 0;
        void'($urandom(32'h9cf8251e));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd({OFS_EN0, 2'b00}, 32'h0);
        check(s, 1'b0);
        rd({OFS_EN1, 2'b00}, 32'h0);
        rd({OFS_RAW, 2'b00}, 32'h0);
        rd({OFS_ST1, 2'b00}, 32'h0);
        rd(18'h00004, 32'h0);
        check(s, 1'b1);
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            apb(1'b1, {OFS_EN0, 2'b00}, r);
            rd({OFS_EN0, 2'b00}, r & MASK0);
            apb(1'b1, {OFS_EN1, 2'b00}, ~r);
            rd({OFS_EN1, 2'b00}, ~r & MASK1);
        end
        // first pass masked, second pass enabled, one event at a time
        for (int i = 0; i < 10; i++) begin
            k = i % 5;
            ev <= (k == 2) ? 4'h8 : 4'h0;
            repeat (6) @(posedge pclk);
            apb(1'b1, {OFS_EN0, 2'b00}, 32'h0);
            apb(1'b1, {OFS_EN1, 2'b00}, 32'h0);
            apb(1'b1, {OFS_ST0, 2'b00}, 32'hffff);
            apb(1'b1, {OFS_ST1, 2'b00}, 32'hffff);
            e = i / 5;
            apb(1'b1, (k < 2) ? {OFS_EN0, 2'b00} : {OFS_EN1, 2'b00}, e << bt[k]);
            ev <= ev ^ sel[k];
            repeat (6) @(posedge pclk);
            check(irq, e);
            paddr <= (k < 2) ? {OFS_ST0, 2'b00} : {OFS_ST1, 2'b00};
            @(posedge pclk);
            rd(paddr, 1 << bt[k]);
            apb(1'b1, paddr, ~(1 << bt[k]));
            rd(paddr, 1 << bt[k]);
            apb(1'b1, paddr, 1 << bt[k]);
            rd(paddr, 32'h0);
            check(irq, 32'h0);
        end
        finish_test();
    end
    initial begin
        #1000000;
        n_fail++;
        finish_test();
    end
endmodule : test_usb_event_interrupt_mask
